// ### core/cae_map.svh
// Numeric constants of the execute stage: flag positions, reset values, counts and steps.
`ifndef CAE_MAP_SVH
`define CAE_MAP_SVH
`define CAE_FLAG_C 0
`define CAE_FLAG_Z 1
`define CAE_FLAG_N 2
`define CAE_FLAG_V 3
`define CAE_FLAG_S 4
`define CAE_FLAG_H 5
`define CAE_FLAG_T 6
`define CAE_STATUS_FLAG_REGISTER_RST 8'h00
`define CAE_REG_RST 8'h00
`define CAE_ALL_ONES 8'hff
`define CAE_ZERO8 8'h00
`define CAE_REG_PROD_LO 5'h00
`define CAE_REG_PROD_HI 5'h01
`define CAE_REG_Z_LO 5'h1e
`define CAE_REG_Z_HI 5'h1f
`define CAE_CYC_ONE 3'h1
`define CAE_CYC_TWO 3'h2
`define CAE_CYC_THREE 3'h3
`define CAE_CYC_FOUR 3'h4
`define CAE_CYC_FIVE 3'h5
`define CAE_STEP_ONE 3'h1
`define CAE_STEP_SKIP1 3'h2
`define CAE_STEP_SKIP2 3'h3
`endif

// ### core/cae_pkg.sv
// Types shared by the execute stage: operation codes and the issue carrier.
package cae_pkg;
  typedef enum logic [5:0] {
    cae_op_add, cae_op_adc, cae_op_add_imm_word, cae_op_sub, cae_op_sub_const,
    cae_op_sbc, cae_op_sub_carry_const, cae_op_sub_imm_word, cae_op_and, cae_op_and_const,
    cae_op_or, cae_op_or_const, cae_op_eor, cae_op_ones_complement_op,
    cae_op_twos_complement_op, cae_op_set_mask_bits, cae_op_clear_mask_bits,
    cae_op_zero_minus_test, cae_op_set_all_ones, cae_op_mul, cae_op_mul_signed,
    cae_op_mult_signed_unsigned, cae_op_frac_mul, cae_op_frac_mul_signed,
    cae_op_frac_mult_signed_unsigned, cae_op_relative_jump, cae_op_indirect_jump,
    cae_op_extended_indirect_jump, cae_op_direct_jump, cae_op_relative_call,
    cae_op_indirect_call, cae_op_extended_indirect_call, cae_op_direct_call,
    cae_op_compare_skip_equal, cae_op_compare, cae_op_compare_carry, cae_op_compare_immediate,
    cae_op_skip_reg_bit_clear, cae_op_skip_reg_bit_set, cae_op_skip_io_bit_clear,
    cae_op_skip_io_bit_set, cae_op_branch_flag_set, cae_op_branch_flag_clear,
    cae_op_branch_signed_ge, cae_op_branch_signed_lt
  } cae_op_t;

  typedef enum logic {cae_st_idle = 1'b0, cae_st_wait = 1'b1} cae_state_t;

  typedef struct packed {
    cae_op_t op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [7:0] imm;
    logic [11:0] k;
    logic [21:0] target;
    logic [2:0] sel;
    logic [7:0] io_bits;
    logic two_word_next;
  } cae_issue_t;
endpackage

// ### core/cae_core.sv
// Execute stage of the 8-bit core: arithmetic, logic, multiply and program flow.
//
// Operation
// - Add with or without carry stores sum, updates Z C N V H in one cycle.
// - Word add of immediate writes the pair, updates Z C N V S, two cycles.
// - Subtract register or constant, optional carry, updates Z C N V H, one cycle.
// - Word subtract of immediate writes the pair, updates Z C N V S, two cycles.
// - AND, OR, XOR update Z N V only, carry untouched, one cycle.
// - Complement is 0xff minus value, negate zero minus value; negate also sets H.
// - Mask clear ANDs with 0xff minus mask, updates Z N V, one cycle.
// - Test ANDs register with itself, value kept, updates Z N V, one cycle.
// - All three multiplies write product to registers one and zero, Z C, two cycles.
// - Fractional multiplies shift product left one before writing, Z C, two cycles.
// - Relative jump loads pc plus offset plus one, two cycles, flags kept.
// - Indirect jumps load Z, extended adds upper byte; two cycles; direct jump three.
// - Relative and indirect calls take four cycles, direct call five, flags kept.
// - Compare-skip-equal skips next on match; one, two or three cycles.
// - Compares compute difference unstored, update Z N V C H, one cycle.
// - Register bit skips test a chosen bit and skip on match, 1/2/3 cycles.
// - I/O bit skips test a chosen I/O bit, skip on clear or set, 1/2/3 cycles.
// - Flag branches add offset plus one when taken; one cycle or two.
// - Signed branches test N xor V, taken on zero or one, one or two cycles.
// - Unsigned branches test carry, taken on clear or set, one or two cycles.
// - Half-carry and T branches exist for set and clear, one or two cycles.
// - Set-all-ones writes 0xff, no flag changes, one cycle.
`timescale 1ns/1ps
`include "cae_map.svh"

module cae_core #(
  parameter int PC_W = 22
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic issue_valid,
  input wire cae_pkg::cae_issue_t issue,
  input wire logic [7:0] extended_indirect_upper,
  input wire logic [4:0] dbg_addr,
  output logic ready,
  output logic [PC_W-1:0] pc,
  output logic [7:0] status_flag_register,
  output logic [7:0] dbg_data
);
  logic [7:0] regs [32];
  cae_pkg::cae_state_t state;
  logic [2:0] cnt;
  logic fire;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] opb;
  logic imm_op;
  logic carry_op;
  logic cin;
  logic [8:0] add_r;
  logic add_cout;
  logic [7:0] sub_a;
  logic [7:0] sub_b;
  logic [8:0] sub_r;
  logic [4:0] pair_lo;
  logic [4:0] pair_hi;
  logic [15:0] word;
  logic [15:0] wsum;
  logic [15:0] wdiff;
  logic sa;
  logic sb;
  logic frac;
  logic [17:0] prod;
  logic [15:0] mres;
  logic prod_msb;
  logic [PC_W-1:0] seq_pc;
  logic [PC_W-1:0] rel_target;
  logic [PC_W-1:0] skip_pc;
  logic [PC_W-1:0] z_target;
  logic [PC_W-1:0] ez_target;
  logic [23:0] ez_full;
  logic [2:0] skip_cyc;
  logic flag_sel;
  logic nv;
  logic carry_flag;
  logic [7:0] next_lo;
  logic [7:0] next_hi;
  logic [4:0] next_lo_idx;
  logic [4:0] next_hi_idx;
  logic next_wr_lo;
  logic next_wr_hi;
  logic [7:0] next_status_flag_register;
  logic [PC_W-1:0] next_pc;
  logic [2:0] next_cyc;
  logic skip;

  // Operand selection and shared adders.
  assign fire = issue_valid & ready;
  assign a = regs[issue.rd];
  assign b = regs[issue.rr];
  assign imm_op = issue.op inside {cae_pkg::cae_op_sub_const, cae_pkg::cae_op_sub_carry_const,
    cae_pkg::cae_op_and_const, cae_pkg::cae_op_or_const, cae_pkg::cae_op_set_mask_bits,
    cae_pkg::cae_op_clear_mask_bits, cae_pkg::cae_op_compare_immediate};
  assign carry_op = issue.op inside {cae_pkg::cae_op_adc, cae_pkg::cae_op_sbc,
    cae_pkg::cae_op_sub_carry_const, cae_pkg::cae_op_compare_carry};
  assign opb = imm_op ? issue.imm : b;
  assign carry_flag = status_flag_register[`CAE_FLAG_C];
  assign cin = carry_op & carry_flag;
  assign add_r = {1'b0, a} + {1'b0, opb} + {8'h00, cin};
  assign add_cout = add_r[8];
  assign sub_a = (issue.op == cae_pkg::cae_op_twos_complement_op) ? `CAE_ZERO8 : a;
  assign sub_b = (issue.op == cae_pkg::cae_op_twos_complement_op) ? a : opb;
  assign sub_r = {1'b0, sub_a} - {1'b0, sub_b} - {8'h00, cin};
  assign pair_lo = {issue.rd[4:1], 1'b0};
  assign pair_hi = {issue.rd[4:1], 1'b1};
  assign word = {regs[pair_hi], regs[pair_lo]};
  assign wsum = word + {10'h000, issue.imm[5:0]};
  assign wdiff = word - {10'h000, issue.imm[5:0]};

  assign sa = issue.op inside {cae_pkg::cae_op_mul_signed, cae_pkg::cae_op_mult_signed_unsigned,
    cae_pkg::cae_op_frac_mul_signed, cae_pkg::cae_op_frac_mult_signed_unsigned};
  assign sb = issue.op inside {cae_pkg::cae_op_mul_signed, cae_pkg::cae_op_frac_mul_signed};
  assign frac = issue.op inside {cae_pkg::cae_op_frac_mul, cae_pkg::cae_op_frac_mul_signed,
    cae_pkg::cae_op_frac_mult_signed_unsigned};
  assign prod = 18'($signed({sa & a[7], a}) * $signed({sb & b[7], b}));
  assign prod_msb = prod[15];
  assign mres = frac ? {prod[14:0], 1'b0} : prod[15:0];

  // Program-flow targets.
  assign seq_pc = pc + PC_W'(`CAE_STEP_ONE);
  assign rel_target = pc + PC_W'($signed(issue.k)) + PC_W'(`CAE_STEP_ONE);
  assign skip_cyc = issue.two_word_next ? `CAE_CYC_THREE : `CAE_CYC_TWO;
  assign skip_pc = pc + PC_W'(issue.two_word_next ? `CAE_STEP_SKIP2 : `CAE_STEP_SKIP1);
  assign z_target = PC_W'({regs[`CAE_REG_Z_HI], regs[`CAE_REG_Z_LO]});
  assign ez_full = {extended_indirect_upper, regs[`CAE_REG_Z_HI], regs[`CAE_REG_Z_LO]};
  assign ez_target = PC_W'(ez_full);
  assign flag_sel = status_flag_register[issue.sel];
  assign nv = status_flag_register[`CAE_FLAG_N] ^ status_flag_register[`CAE_FLAG_V];

  // Flags of 8-bit add and subtract; carrying subtracts only keep Z low once it is low.
  function automatic logic [7:0] arith_flags(input logic [7:0] x, input logic [7:0] y,
                                             input logic [7:0] r, input logic [7:0] sr,
                                             input logic sub, input logic keep_z);
    logic [7:0] f;
    f = sr;
    if (sub) begin
      f[`CAE_FLAG_H] = (~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]);
      f[`CAE_FLAG_C] = (~x[7] & y[7]) | (y[7] & r[7]) | (r[7] & ~x[7]);
      f[`CAE_FLAG_V] = (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]);
    end else begin
      f[`CAE_FLAG_H] = (x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]);
      f[`CAE_FLAG_C] = (x[7] & y[7]) | (y[7] & ~r[7]) | (~r[7] & x[7]);
      f[`CAE_FLAG_V] = (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]);
    end
    f[`CAE_FLAG_N] = r[7];
    f[`CAE_FLAG_Z] = (r == `CAE_ZERO8) & (~keep_z | sr[`CAE_FLAG_Z]);
    return f;
  endfunction

  // Flags of logic results: V cleared, C and H kept.
  function automatic logic [7:0] logic_flags(input logic [7:0] r, input logic [7:0] sr);
    logic [7:0] f;
    f = sr;
    f[`CAE_FLAG_V] = 1'b0;
    f[`CAE_FLAG_N] = r[7];
    f[`CAE_FLAG_Z] = (r == `CAE_ZERO8);
    return f;
  endfunction

  // Flags of word add and subtract.
  function automatic logic [7:0] word_flags(input logic [15:0] w, input logic [15:0] r,
                                            input logic [7:0] sr, input logic sub);
    logic [7:0] f;
    f = sr;
    f[`CAE_FLAG_V] = sub ? (w[15] & ~r[15]) : (~w[15] & r[15]);
    f[`CAE_FLAG_C] = sub ? (r[15] & ~w[15]) : (~r[15] & w[15]);
    f[`CAE_FLAG_N] = r[15];
    f[`CAE_FLAG_Z] = (r == 16'h0000);
    f[`CAE_FLAG_S] = r[15] ^ f[`CAE_FLAG_V];
    return f;
  endfunction

  always_comb begin
    next_lo = a;
    next_hi = `CAE_ZERO8;
    next_lo_idx = issue.rd;
    next_hi_idx = pair_hi;
    next_wr_lo = 1'b0;
    next_wr_hi = 1'b0;
    next_status_flag_register = status_flag_register;
    next_pc = seq_pc;
    next_cyc = `CAE_CYC_ONE;
    skip = 1'b0;
    case (issue.op)
      cae_pkg::cae_op_add, cae_pkg::cae_op_adc: begin
        next_lo = add_r[7:0];
        next_wr_lo = 1'b1;
        next_status_flag_register = arith_flags(a, opb, add_r[7:0], status_flag_register, 1'b0, 1'b0);
      end
      cae_pkg::cae_op_sub, cae_pkg::cae_op_sub_const, cae_pkg::cae_op_sbc,
      cae_pkg::cae_op_sub_carry_const: begin
        next_lo = sub_r[7:0];
        next_wr_lo = 1'b1;
        next_status_flag_register = arith_flags(a, opb, sub_r[7:0], status_flag_register, 1'b1, carry_op);
      end
      cae_pkg::cae_op_compare, cae_pkg::cae_op_compare_carry,
      cae_pkg::cae_op_compare_immediate: begin
        next_status_flag_register = arith_flags(a, opb, sub_r[7:0], status_flag_register, 1'b1, carry_op);
      end
      cae_pkg::cae_op_add_imm_word: begin
        {next_hi, next_lo} = wsum;
        next_lo_idx = pair_lo;
        next_wr_lo = 1'b1;
        next_wr_hi = 1'b1;
        next_status_flag_register = word_flags(word, wsum, status_flag_register, 1'b0);
        next_cyc = `CAE_CYC_TWO;
      end
      cae_pkg::cae_op_sub_imm_word: begin
        {next_hi, next_lo} = wdiff;
        next_lo_idx = pair_lo;
        next_wr_lo = 1'b1;
        next_wr_hi = 1'b1;
        next_status_flag_register = word_flags(word, wdiff, status_flag_register, 1'b1);
        next_cyc = `CAE_CYC_TWO;
      end
      cae_pkg::cae_op_and, cae_pkg::cae_op_and_const, cae_pkg::cae_op_zero_minus_test: begin
        next_lo = a & opb;
        next_wr_lo = (issue.op != cae_pkg::cae_op_zero_minus_test);
        next_status_flag_register = logic_flags(a & ((issue.op == cae_pkg::cae_op_zero_minus_test) ? a : opb),
                                status_flag_register);
      end
      cae_pkg::cae_op_or, cae_pkg::cae_op_or_const, cae_pkg::cae_op_set_mask_bits: begin
        next_lo = a | opb;
        next_wr_lo = 1'b1;
        next_status_flag_register = logic_flags(a | opb, status_flag_register);
      end
      cae_pkg::cae_op_eor: begin
        next_lo = a ^ opb;
        next_wr_lo = 1'b1;
        next_status_flag_register = logic_flags(a ^ opb, status_flag_register);
      end
      cae_pkg::cae_op_clear_mask_bits: begin
        next_lo = a & (`CAE_ALL_ONES - opb);
        next_wr_lo = 1'b1;
        next_status_flag_register = logic_flags(a & (`CAE_ALL_ONES - opb), status_flag_register);
      end
      cae_pkg::cae_op_ones_complement_op: begin
        next_lo = `CAE_ALL_ONES - a;
        next_wr_lo = 1'b1;
        next_status_flag_register = logic_flags(`CAE_ALL_ONES - a, status_flag_register);
        next_status_flag_register[`CAE_FLAG_C] = 1'b1;
      end
      cae_pkg::cae_op_twos_complement_op: begin
        next_lo = sub_r[7:0];
        next_wr_lo = 1'b1;
        next_status_flag_register = arith_flags(sub_a, sub_b, sub_r[7:0], status_flag_register, 1'b1, 1'b0);
      end
      cae_pkg::cae_op_set_all_ones: begin
        next_lo = `CAE_ALL_ONES;
        next_wr_lo = 1'b1;
      end
      cae_pkg::cae_op_mul, cae_pkg::cae_op_mul_signed, cae_pkg::cae_op_mult_signed_unsigned,
      cae_pkg::cae_op_frac_mul, cae_pkg::cae_op_frac_mul_signed,
      cae_pkg::cae_op_frac_mult_signed_unsigned: begin
        {next_hi, next_lo} = mres;
        next_lo_idx = `CAE_REG_PROD_LO;
        next_hi_idx = `CAE_REG_PROD_HI;
        next_wr_lo = 1'b1;
        next_wr_hi = 1'b1;
        next_status_flag_register[`CAE_FLAG_C] = prod_msb;
        next_status_flag_register[`CAE_FLAG_Z] = (mres == 16'h0000);
        next_cyc = `CAE_CYC_TWO;
      end
      cae_pkg::cae_op_relative_jump: begin
        next_pc = rel_target;
        next_cyc = `CAE_CYC_TWO;
      end
      cae_pkg::cae_op_indirect_jump: begin
        next_pc = z_target;
        next_cyc = `CAE_CYC_TWO;
      end
      cae_pkg::cae_op_extended_indirect_jump: begin
        next_pc = ez_target;
        next_cyc = `CAE_CYC_TWO;
      end
      cae_pkg::cae_op_direct_jump: begin
        next_pc = PC_W'(issue.target);
        next_cyc = `CAE_CYC_THREE;
      end
      cae_pkg::cae_op_relative_call: begin
        next_pc = rel_target;
        next_cyc = `CAE_CYC_FOUR;
      end
      cae_pkg::cae_op_indirect_call: begin
        next_pc = z_target;
        next_cyc = `CAE_CYC_FOUR;
      end
      cae_pkg::cae_op_extended_indirect_call: begin
        next_pc = ez_target;
        next_cyc = `CAE_CYC_FOUR;
      end
      cae_pkg::cae_op_direct_call: begin
        next_pc = PC_W'(issue.target);
        next_cyc = `CAE_CYC_FIVE;
      end
      cae_pkg::cae_op_compare_skip_equal: skip = (a == b);
      cae_pkg::cae_op_skip_reg_bit_clear: skip = ~b[issue.sel];
      cae_pkg::cae_op_skip_reg_bit_set: skip = b[issue.sel];
      cae_pkg::cae_op_skip_io_bit_clear: skip = ~issue.io_bits[issue.sel];
      cae_pkg::cae_op_skip_io_bit_set: skip = issue.io_bits[issue.sel];
      // Flag branch, also C, H and T forms.
      cae_pkg::cae_op_branch_flag_set, cae_pkg::cae_op_branch_flag_clear: begin
        if (flag_sel == (issue.op == cae_pkg::cae_op_branch_flag_set)) begin
          next_pc = rel_target;
          next_cyc = `CAE_CYC_TWO;
        end
      end
      cae_pkg::cae_op_branch_signed_ge, cae_pkg::cae_op_branch_signed_lt: begin
        if (nv == (issue.op == cae_pkg::cae_op_branch_signed_lt)) begin
          next_pc = rel_target;
          next_cyc = `CAE_CYC_TWO;
        end
      end
      default: next_cyc = `CAE_CYC_ONE;
    endcase
    if (skip) begin
      next_pc = skip_pc;
      next_cyc = skip_cyc;
    end
  end

  // Architectural state commits on the issue edge; later cycles only stall.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= `CAE_REG_RST;
      end
    end else if (fire) begin
      if (next_wr_lo) begin
        regs[next_lo_idx] <= next_lo;
      end
      if (next_wr_hi) begin
        regs[next_hi_idx] <= next_hi;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pc <= '0;
      status_flag_register <= `CAE_STATUS_FLAG_REGISTER_RST;
      dbg_data <= `CAE_REG_RST;
    end else begin
      dbg_data <= regs[dbg_addr];
      if (fire) begin
        pc <= next_pc;
        status_flag_register <= next_status_flag_register;
      end
    end
  end

  // Cycle counts are honoured by holding ready low for the remaining cycles.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= cae_pkg::cae_st_idle;
      cnt <= '0;
      ready <= 1'b1;
    end else begin
      case (state)
        cae_pkg::cae_st_idle: begin
          if (fire && next_cyc != `CAE_CYC_ONE) begin
            state <= cae_pkg::cae_st_wait;
            cnt <= next_cyc - `CAE_CYC_ONE;
            ready <= 1'b0;
          end
        end
        cae_pkg::cae_st_wait: begin
          cnt <= cnt - `CAE_CYC_ONE;
          if (cnt == `CAE_CYC_ONE) begin
            state <= cae_pkg::cae_st_idle;
            ready <= 1'b1;
          end
        end
        default: state <= cae_pkg::cae_st_idle;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_stall_one;
    !ready ##1 ready;
  endsequence
  sequence s_stall_two;
    !ready [*2] ##1 ready;
  endsequence

  property p_add_carry;
    fire && issue.op == cae_pkg::cae_op_add |=>
      ready && status_flag_register[`CAE_FLAG_C] == $past(add_cout);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");
  property p_word_add;
    fire && issue.op == cae_pkg::cae_op_add_imm_word |=> s_stall_one;
  endproperty
  a_word_add: assert property (p_word_add) else $error("word add not two cycles");
  property p_word_sub;
    fire && issue.op == cae_pkg::cae_op_sub_imm_word |=> s_stall_one;
  endproperty
  a_word_sub: assert property (p_word_sub) else $error("word sub not two cycles");
  property p_logic_carry;
    fire && issue.op == cae_pkg::cae_op_eor |=>
      !status_flag_register[`CAE_FLAG_V] && status_flag_register[`CAE_FLAG_C] == $past(carry_flag);
  endproperty
  a_logic_carry: assert property (p_logic_carry) else $error("logic op touched C or V");
  property p_mul;
    fire && issue.op == cae_pkg::cae_op_mul |=> status_flag_register[`CAE_FLAG_C] == $past(prod_msb)
      ##0 s_stall_one;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply carry or timing wrong");
  property p_rel_jump;
    fire && issue.op == cae_pkg::cae_op_relative_jump |=> pc == $past(rel_target)
      && status_flag_register == $past(status_flag_register);
  endproperty
  a_rel_jump: assert property (p_rel_jump) else $error("relative jump target wrong");
  property p_direct_jump;
    fire && issue.op == cae_pkg::cae_op_direct_jump |=> s_stall_two;
  endproperty
  a_direct_jump: assert property (p_direct_jump) else $error("direct jump not three");
  property p_direct_call;
    fire && issue.op == cae_pkg::cae_op_direct_call |=> !ready [*4] ##1 ready;
  endproperty
  a_direct_call: assert property (p_direct_call) else $error("direct call not five");
  property p_skip_long;
    fire && issue.op == cae_pkg::cae_op_compare_skip_equal && a == b && issue.two_word_next
      |=> pc == $past(skip_pc) ##0 s_stall_two;
  endproperty
  a_skip_long: assert property (p_skip_long) else $error("long skip wrong");
  property p_branch_ge;
    fire && issue.op == cae_pkg::cae_op_branch_signed_ge && !nv |=> pc == $past(rel_target);
  endproperty
  a_branch_ge: assert property (p_branch_ge) else $error("signed branch not taken");
  property p_set_ones;
    fire && issue.op == cae_pkg::cae_op_set_all_ones |=>
      ready && status_flag_register == $past(status_flag_register);
  endproperty
  a_set_ones: assert property (p_set_ones) else $error("set all ones changed flags");
endmodule

// ### dv/cae_io_model.sv
// Far-side I/O register model that supplies the tested I/O value.
`timescale 1ns/1ps
module cae_io_model #(
  parameter logic [7:0] IO_VAL = 8'ha5
) (
  input wire logic core_clk,
  output logic [7:0] io_val
);
  always_ff @(posedge core_clk) begin
    io_val <= IO_VAL;
  end
endmodule

// ### dv/cae_core_bench.sv
// Self-checking bench for the execute stage.
`timescale 1ns/1ps
module cae_core_bench;
  logic core_clk, rstn, issue_valid, ready, two_next;
  cae_pkg::cae_issue_t issue;
  logic [7:0] upper, flags, dbg_data, io_val;
  logic [4:0] dbg_addr;
  logic [21:0] pc, ep;
  int n_fail = 0;
  int compares = 0;
  cae_core i_dut (.core_clk(core_clk), .rstn(rstn), .issue_valid(issue_valid), .issue(issue),
    .extended_indirect_upper(upper), .dbg_addr(dbg_addr), .ready(ready), .pc(pc),
    .status_flag_register(flags), .dbg_data(dbg_data));
  cae_io_model i_io (.core_clk(core_clk), .io_val(io_val));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Direct targets equal the expected pc, so one argument serves both.
  task automatic run(input cae_pkg::cae_op_t op, input int rd, input int rr, input int imm,
      input logic [21:0] npc, input int cyc);
    int n;
    @(posedge core_clk);
    issue_valid <= 1'b1;
    issue <= '{op, 5'(rd), 5'(rr), 8'(imm), 12'(signed'(8'(imm))), npc, 3'(rr), io_val, two_next};
    @(posedge core_clk);
    issue_valid <= 1'b0;
    #1;
    n = 1;
    while (ready !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("cycles", 22'(cyc), 22'(n));
    chk("pc", npc, pc);
    ep = npc;
  endtask
  task automatic fl(input int e);
    chk("flags", 22'(e), 22'(flags));
  endtask
  task automatic reg_is(input int a, input int e);
    @(posedge core_clk);
    dbg_addr <= 5'(a);
    repeat (2) @(posedge core_clk);
    #1;
    chk("reg", 22'(e), 22'(dbg_data));
  endtask
  task automatic ld(input int a, input int v);
    run(cae_pkg::cae_op_set_all_ones, a, 0, 0, ep + 1, 1);
    run(cae_pkg::cae_op_and_const, a, 0, v, ep + 1, 1);
  endtask
  task automatic t_arith;
    ld(16, 8'h0f);
    ld(17, 8'h01);
    run(cae_pkg::cae_op_add, 16, 17, 0, ep + 1, 1);
    fl(8'h20);
    reg_is(16, 8'h10);
    run(cae_pkg::cae_op_sub_const, 18, 0, 1, ep + 1, 1);
    fl(8'h25);
    run(cae_pkg::cae_op_ones_complement_op, 18, 0, 0, ep + 1, 1);
    fl(8'h23);
    run(cae_pkg::cae_op_twos_complement_op, 17, 0, 0, ep + 1, 1);
    fl(8'h25);
    reg_is(17, 8'hff);
  endtask
  task automatic t_logic;
    run(cae_pkg::cae_op_set_all_ones, 19, 0, 0, ep + 1, 1);
    fl(8'h25);
    run(cae_pkg::cae_op_clear_mask_bits, 19, 0, 8'hf0, ep + 1, 1);
    fl(8'h21);
    reg_is(19, 8'h0f);
    run(cae_pkg::cae_op_zero_minus_test, 17, 0, 0, ep + 1, 1);
    fl(8'h25);
    run(cae_pkg::cae_op_eor, 19, 19, 0, ep + 1, 1);
    fl(8'h23);
    run(cae_pkg::cae_op_compare, 16, 16, 0, ep + 1, 1);
    fl(8'h02);
    reg_is(16, 8'h10);
  endtask
  task automatic t_mul;
    run(cae_pkg::cae_op_mul, 17, 17, 0, ep + 1, 2);
    fl(8'h01);
    reg_is(1, 8'hfe);
    reg_is(0, 8'h01);
    run(cae_pkg::cae_op_frac_mul, 17, 17, 0, ep + 1, 2);
    reg_is(1, 8'hfc);
    reg_is(0, 8'h02);
    run(cae_pkg::cae_op_set_all_ones, 24, 0, 0, ep + 1, 1);
    run(cae_pkg::cae_op_add_imm_word, 24, 0, 1, ep + 1, 2);
    fl(8'h00);
    reg_is(25, 8'h01);
    run(cae_pkg::cae_op_sub_imm_word, 24, 0, 1, ep + 1, 2);
    reg_is(24, 8'hff);
  endtask
  task automatic t_flow;
    run(cae_pkg::cae_op_direct_jump, 0, 0, 0, 22'h100, 3);
    run(cae_pkg::cae_op_relative_jump, 0, 0, 8'hfe, 22'h0ff, 2);
    run(cae_pkg::cae_op_relative_call, 0, 0, 8'h10, 22'h110, 4);
    run(cae_pkg::cae_op_direct_call, 0, 0, 0, 22'h3fff00, 5);
    ld(30, 8'h34);
    ld(31, 8'h12);
    run(cae_pkg::cae_op_indirect_jump, 0, 0, 0, 22'h001234, 2);
    run(cae_pkg::cae_op_extended_indirect_jump, 0, 0, 0, 22'h051234, 2);
    run(cae_pkg::cae_op_extended_indirect_call, 0, 0, 0, 22'h051234, 4);
    fl(8'h00);
  endtask
  task automatic t_skip;
    two_next = 1'b1;
    run(cae_pkg::cae_op_compare_skip_equal, 16, 16, 0, ep + 3, 3);
    two_next = 1'b0;
    run(cae_pkg::cae_op_compare_skip_equal, 16, 17, 0, ep + 1, 1);
    run(cae_pkg::cae_op_skip_reg_bit_clear, 16, 16, 0, ep + 2, 2);
    run(cae_pkg::cae_op_skip_reg_bit_set, 16, 16, 0, ep + 1, 1);
    run(cae_pkg::cae_op_skip_io_bit_clear, 0, 1, 0, ep + 2, 2);
    run(cae_pkg::cae_op_skip_io_bit_set, 0, 1, 0, ep + 1, 1);
    run(cae_pkg::cae_op_skip_reg_bit_set, 0, 17, 0, ep + 2, 2);
    run(cae_pkg::cae_op_skip_io_bit_set, 0, 0, 0, ep + 2, 2);
  endtask
  task automatic t_branch;
    run(cae_pkg::cae_op_branch_flag_clear, 0, 0, 3, ep + 4, 2);
    run(cae_pkg::cae_op_branch_flag_set, 0, 0, 3, ep + 1, 1);
    run(cae_pkg::cae_op_branch_signed_ge, 0, 0, 8'hfc, ep - 3, 2);
    run(cae_pkg::cae_op_branch_signed_lt, 0, 0, 8'hfc, ep + 1, 1);
    run(cae_pkg::cae_op_branch_flag_set, 0, 5, 3, ep + 1, 1);
    run(cae_pkg::cae_op_branch_flag_clear, 0, 6, 3, ep + 4, 2);
  endtask
  // Carry-in, immediate compare, signed multiplies and carrying compare keeping Z low.
  task automatic t_more;
    run(cae_pkg::cae_op_compare_immediate, 16, 0, 8'h20, ep + 1, 1);
    fl(8'h05);
    run(cae_pkg::cae_op_adc, 16, 16, 0, ep + 1, 1);
    fl(8'h00);
    reg_is(16, 8'h21);
    run(cae_pkg::cae_op_or, 19, 16, 0, ep + 1, 1);
    reg_is(19, 8'h21);
    run(cae_pkg::cae_op_mult_signed_unsigned, 17, 16, 0, ep + 1, 2);
    fl(8'h01);
    reg_is(1, 8'hff);
    reg_is(0, 8'hdf);
    run(cae_pkg::cae_op_frac_mul_signed, 17, 17, 0, ep + 1, 2);
    fl(8'h00);
    reg_is(0, 8'h02);
    run(cae_pkg::cae_op_compare_carry, 16, 16, 0, ep + 1, 1);
    fl(8'h00);
  endtask
  initial begin
    rstn = 1'b0;
    issue_valid = 1'b0;
    issue = '0;
    upper = 8'h05;
    dbg_addr = 5'h00;
    two_next = 1'b0;
    ep = 22'h0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk("pc", 22'h0, pc);
    fl(8'h00);
    t_arith();
    t_logic();
    t_mul();
    t_flow();
    t_skip();
    t_branch();
    t_more();
    stop_test();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge core_clk);
    n_fail++;
    stop_test();
  end
endmodule
